// ===== logic/panel_scan_pkg.sv
// Constants shared by the front-panel scanner logic.
// Assumes a single 100 MHz clock and processor strobes far slower than it.
`default_nettype none

package panel_scan_pkg;

    // Chain layout: digits first, then switch-LED groups, last stage reads the encoder
    localparam int DIGIT_COUNT    = 14;
    localparam int LED_GROUPS     = 5;
    localparam int CHAIN_LEN      = DIGIT_COUNT + LED_GROUPS;
    localparam int FINAL_STAGE    = CHAIN_LEN - 1;
    localparam int KEY_GROUPS     = 8;
    localparam int KEY_LINES      = 8;
    localparam int SEG_WIDTH      = 8;
    localparam int ANNUN_GROUPS   = 4;
    localparam int SYNC_STAGES    = 2;

    // Group holding only seven switches, and its unused return line
    localparam int SHORT_GROUP    = 1;
    localparam int SHORT_LINE     = 7;

    // Encoder flags ride on the two highest return lines
    localparam int ENC_HIGH_LINE  = 7;
    localparam int ENC_LOW_LINE   = 6;

    // Reset values
    localparam logic [CHAIN_LEN-1:0] TOKEN_RESET = 19'h00000;
    localparam logic [SEG_WIDTH-1:0] SEG_RESET   = 8'h00;
    localparam logic [KEY_LINES-1:0] KEYS_IDLE   = 8'h00;

    // Nominal step period of the scan clock, in microseconds (host side)
    localparam int STEP_PERIOD_US = 500;

endpackage : panel_scan_pkg

`default_nettype wire

// ===== logic/sync_bits.sv
// Two-flop synchroniser for a group of asynchronous pin inputs.
// Assumes each bit is a slow level; bits are not sampled as a coherent word.
`default_nettype none

module sync_bits #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async,
    output var  logic [WIDTH-1:0] synced
);

    logic [WIDTH-1:0] meta_q;

    ////////////////////////////////////////////////////////////////////////////////
    // First stage feeds only the second stage
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            synced <= '0;
        end
        else
        begin
            meta_q <= async;
            synced <= meta_q;
        end
    end

endmodule // sync_bits

`default_nettype wire

// ===== logic/led_scan_keyboard_rotary.sv
// Front-panel scanner: token chain for digits and switch LEDs, key matrix,
// encoder flags and strobe-reloaded indicator latches.
// Assumes the processor drives all inputs as slow pins on its own timing.
`default_nettype none

// Operation
// R1: Host latches first pattern, then raises serial input
// R2: Host drops serial input, presents next pattern
// R3: Scan clock shifts token and latches pattern
// R4: Fourteen digits first, then switch-LED groups
// R5: Host steps clock about every half millisecond
// R6: At most one digit or group energised
// R7: Strobed indicator group holds; others unaffected
// R8: First eight stages drive key groups
// R9: Return lines low unless key pressed
// R10: Host decodes key from group and line
// R11: Host debounces keys in software
// R12: Final stage blocks keys, shows encoder flags
// R13: Rotation sets flags by direction
// R14: New scan start clears encoder flags
// R15: Reset leaves chain empty, enables off
module led_scan_keyboard_rotary (
    input  wire logic                                   clock,
    input  wire logic                                   rst_n,
    input  wire logic                                   scanClock,
    input  wire logic                                   scanSerialIn,
    input  wire logic [panel_scan_pkg::SEG_WIDTH-1:0]   segmentPatternBus,
    input  wire logic [panel_scan_pkg::ANNUN_GROUPS-1:0] indicatorGroupStrobes_n,
    input  wire logic [panel_scan_pkg::KEY_LINES-1:0]   keySense,
    input  wire logic                                   encoderA,
    input  wire logic                                   encoderB,
    output var  logic [panel_scan_pkg::DIGIT_COUNT-1:0] digitPositions,
    output var  logic [panel_scan_pkg::LED_GROUPS-1:0]  ledGroupEnable,
    output var  logic [panel_scan_pkg::SEG_WIDTH-1:0]   segmentDrive,
    output var  logic [panel_scan_pkg::KEY_GROUPS-1:0]  keyGroupDrive_n,
    output var  logic [panel_scan_pkg::KEY_LINES-1:0]   keyReturn,
    output var  logic [panel_scan_pkg::SEG_WIDTH*panel_scan_pkg::ANNUN_GROUPS-1:0] indicators
);

    localparam int CL = panel_scan_pkg::CHAIN_LEN;
    localparam int SW = panel_scan_pkg::SEG_WIDTH;
    localparam int AG = panel_scan_pkg::ANNUN_GROUPS;
    localparam int KL = panel_scan_pkg::KEY_LINES;
    localparam int SYNC_W = 1 + 1 + SW + AG + KL + 1 + 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisation
    logic [1:0]        rstPipe_q;
    logic              rstSync_n;
    logic [SYNC_W-1:0] syncOut;
    logic              clkS;
    logic              serS;
    logic [SW-1:0]     segS;
    logic [AG-1:0]     strobeS_n;
    logic [KL-1:0]     keyS;
    logic              encAS;
    logic              encBS;

    // Asynchronous assert, synchronous release
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rstPipe_q <= 2'h0;
        else
            rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
    assign rstSync_n = rstPipe_q[1];

    sync_bits #(.WIDTH(SYNC_W)) pinSync (
        .clock  (clock),
        .rst_n  (rstSync_n),
        .async  ({scanClock, scanSerialIn, segmentPatternBus, indicatorGroupStrobes_n,
                  keySense, encoderA, encoderB}),
        .synced (syncOut)
    );
    assign {clkS, serS, segS, strobeS_n, keyS, encAS, encBS} = syncOut;

    ////////////////////////////////////////////////////////////////////////////////
    // State
    logic              clkPrev_q,   clkPrev_d;
    logic              serPrev_q,   serPrev_d;
    logic [AG-1:0]     strobePrev_q, strobePrev_d;
    logic              encAPrev_q,  encAPrev_d;
    logic [CL-1:0]     token_q,     token_d;
    logic [SW-1:0]     segLatch_q,  segLatch_d;
    logic [SW*AG-1:0]  annun_q,     annun_d;
    logic              encHigh_q,   encHigh_d;
    logic              encLow_q,    encLow_d;
    logic [KL-1:0]     keyRet_q,    keyRet_d;
    logic [panel_scan_pkg::KEY_GROUPS-1:0] keyDrive_q, keyDrive_d;
    logic              stepPulse;
    logic              scanStart;
    logic              encStep;

    // Returns true when no more than one bit is set
    function automatic logic atMostOne(input logic [CL-1:0] v);
        return (v & (v - CL'(1))) == '0;
    endfunction

    assign stepPulse = clkS & ~clkPrev_q;
    assign scanStart = serS & ~serPrev_q;
    assign encStep   = encAS & ~encAPrev_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        clkPrev_d    = clkS;
        serPrev_d    = serS;
        strobePrev_d = strobeS_n;
        encAPrev_d   = encAS;
        token_d      = token_q;
        segLatch_d   = segLatch_q;
        annun_d      = annun_q;
        encHigh_d    = encHigh_q;
        encLow_d     = encLow_q;
        keyRet_d     = panel_scan_pkg::KEYS_IDLE;
        // R3: shift token, latch pattern
        if (stepPulse)
        begin
            token_d    = {token_q[CL-2:0], serS};
            segLatch_d = segS;
        end
        // R7: falling strobe loads one group
        for (int g = 0; g < AG; g++)
        begin
            if (strobePrev_q[g] && !strobeS_n[g])
                annun_d[g*SW +: SW] = segS;
        end
        // R14: clear flags at scan start
        if (scanStart)
        begin
            encHigh_d = 1'b0;
            encLow_d  = 1'b0;
        end
        // R13: rotation sets flags, wins over clear
        if (encStep)
        begin
            encHigh_d = 1'b1;
            if (encBS)
                encLow_d = 1'b1;
        end
        // R8: first eight stages drive key groups
        keyDrive_d = ~token_d[panel_scan_pkg::KEY_GROUPS-1:0];
        // R12: final stage shows only encoder flags
        if (token_q[panel_scan_pkg::FINAL_STAGE])
        begin
            keyRet_d[panel_scan_pkg::ENC_HIGH_LINE] = encHigh_q;
            keyRet_d[panel_scan_pkg::ENC_LOW_LINE]  = encLow_q;
        end
        // R9: pressed key in active group reads high
        else if (|token_q[panel_scan_pkg::KEY_GROUPS-1:0])
        begin
            keyRet_d = keyS;
            if (token_q[panel_scan_pkg::SHORT_GROUP])
                keyRet_d[panel_scan_pkg::SHORT_LINE] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    // R15: empty chain, all enables off
    always_ff @(posedge clock or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            clkPrev_q    <= 1'b0;
            serPrev_q    <= 1'b0;
            strobePrev_q <= '0; // Matches the synchroniser's reset level: no false fall
            encAPrev_q   <= 1'b0;
            token_q      <= panel_scan_pkg::TOKEN_RESET;
            segLatch_q   <= panel_scan_pkg::SEG_RESET;
            annun_q      <= '0;
            encHigh_q    <= 1'b0;
            encLow_q     <= 1'b0;
            keyRet_q     <= panel_scan_pkg::KEYS_IDLE;
            keyDrive_q   <= '1;
        end
        else
        begin
            clkPrev_q    <= clkPrev_d;
            serPrev_q    <= serPrev_d;
            strobePrev_q <= strobePrev_d;
            encAPrev_q   <= encAPrev_d;
            token_q      <= token_d;
            segLatch_q   <= segLatch_d;
            annun_q      <= annun_d;
            encHigh_q    <= encHigh_d;
            encLow_q     <= encLow_d;
            keyRet_q     <= keyRet_d;
            keyDrive_q   <= keyDrive_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    // R4: digits low stages, LED groups high
    // R6: enables are token bits
    assign digitPositions  = token_q[panel_scan_pkg::DIGIT_COUNT-1:0];
    assign ledGroupEnable  = token_q[CL-1:panel_scan_pkg::DIGIT_COUNT];
    assign segmentDrive    = segLatch_q;
    assign keyGroupDrive_n = keyDrive_q;
    assign keyReturn       = keyRet_q;
    assign indicators      = annun_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstSync_n);

    sequence stepSeen;
        stepPulse;
    endsequence

    sequence tokenMoved;
        token_q == {$past(token_q[CL-2:0]), $past(serS)};
    endsequence

    // R3: shift on step
    AST_SHIFT: assert property (stepSeen |=> tokenMoved) // R3
        else $error("token did not shift on scan step");

    // R3: pattern latched with step
    AST_SEG_LATCH: assert property (stepPulse |=> segmentDrive == $past(segS)) // R3
        else $error("segment pattern not latched on step");

    // R3: token still without step
    AST_HOLD: assert property (!stepPulse |=> $stable(token_q)) // R3
        else $error("token moved without scan step");

    // R6: one position at most
    AST_ONE_HOT: assert property (atMostOne({ledGroupEnable, digitPositions})) // R6
        else $error("more than one position energised");

    // R4: last digit passes to first LED group
    AST_ORDER: assert property ( // R4
        stepPulse && digitPositions[panel_scan_pkg::DIGIT_COUNT-1] |=> ledGroupEnable[0])
        else $error("last digit did not pass to LED group");

    // R8: key group drive follows token
    AST_KEY_DRIVE: assert property ( // R8
        keyGroupDrive_n == ~token_q[panel_scan_pkg::KEY_GROUPS-1:0])
        else $error("key group drive does not match token");

    // R9: idle return lines low
    AST_KEY_IDLE: assert property (token_q == '0 |=> keyReturn == panel_scan_pkg::KEYS_IDLE) // R9
        else $error("return lines high with no group active");

    // R12: final stage masks keys
    AST_FINAL: assert property ( // R12
        token_q[panel_scan_pkg::FINAL_STAGE]
        |=> keyReturn[5:0] == 6'h00
            && keyReturn[panel_scan_pkg::ENC_HIGH_LINE] == $past(encHigh_q)
            && keyReturn[panel_scan_pkg::ENC_LOW_LINE] == $past(encLow_q))
        else $error("final stage leaked key lines");

    // R14: flags clear at scan start without rotation
    AST_ENC_CLEAR: assert property (scanStart && !encStep |=> !encHigh_q && !encLow_q) // R14
        else $error("encoder flags not cleared at scan start");

    // R13: rotation sets high flag, low one by direction
    AST_ENC_SET: assert property (encStep |=> encHigh_q && (encLow_q || !$past(encBS))) // R13
        else $error("encoder flags not set by rotation");

    // R7: all groups hold their pattern when no strobe falls
    AST_ANNUN_HOLD: assert property (!(|(strobePrev_q & ~strobeS_n)) |=> $stable(annun_q)) // R7
        else $error("indicator changed without strobe");

endmodule // led_scan_keyboard_rotary

`default_nettype wire

// ===== dv/panel_host.sv
// Host model: drives the scan step, token, segment bus and indicator strobes.
// Assumes the bench supplies the clock; steps are shortened to tens of clocks.
`default_nettype none

module panel_host (
    input  wire logic                                    clock,
    output var  logic                                    scanClock,
    output var  logic                                    scanSerialIn,
    output var  logic [panel_scan_pkg::SEG_WIDTH-1:0]    segmentPatternBus,
    output var  logic [panel_scan_pkg::ANNUN_GROUPS-1:0] indicatorGroupStrobes_n
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle pin levels at time zero
    initial
    begin
        scanClock               = 1'b0;
        scanSerialIn            = 1'b0;
        segmentPatternBus       = 8'h00;
        indicatorGroupStrobes_n = 4'hF;
    end

    // Waits and lands just after the edge
    task automatic waitClocks(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic step(input logic token, input logic [7:0] pattern);
        segmentPatternBus = pattern;
        scanSerialIn      = token;
        waitClocks(6);
        scanClock = 1'b1;
        waitClocks(8);
        scanClock    = 1'b0;
        scanSerialIn = 1'b0;
        waitClocks(6);
    endtask

    task automatic strobe(input int g, input logic [7:0] data);
        segmentPatternBus = data;
        waitClocks(6);
        indicatorGroupStrobes_n[g] = 1'b0;
        waitClocks(4);
        indicatorGroupStrobes_n = 4'hF;
        waitClocks(4);
    endtask
endmodule // panel_host

`default_nettype wire

// ===== dv/test_led_scan_keyboard_rotary.sv
// Testbench for the front-panel scanner, with the host model on its pins.
// Assumes one 100 MHz clock; all pins are driven 1 ns after the rising edge.
`default_nettype none

module test_led_scan_keyboard_rotary;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clock;
    logic        rst_n;
    logic        scanClock;
    logic        scanSerialIn;
    logic [7:0]  segmentPatternBus;
    logic [3:0]  indicatorGroupStrobes_n;
    logic [7:0]  keySense;
    logic        encoderA;
    logic        encoderB;
    logic [13:0] digitPositions;
    logic [4:0]  ledGroupEnable;
    logic [7:0]  segmentDrive;
    logic [7:0]  keyGroupDrive_n;
    logic [7:0]  keyReturn;
    logic [31:0] indicators;
    int          fails = 0;
    int          checked = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Host model and design
    panel_host i_host (.clock(clock), .scanClock(scanClock), .scanSerialIn(scanSerialIn),
        .segmentPatternBus(segmentPatternBus),
        .indicatorGroupStrobes_n(indicatorGroupStrobes_n));
    led_scan_keyboard_rotary i_dut (.clock(clock), .rst_n(rst_n), .scanClock(scanClock),
        .scanSerialIn(scanSerialIn), .segmentPatternBus(segmentPatternBus),
        .indicatorGroupStrobes_n(indicatorGroupStrobes_n), .keySense(keySense),
        .encoderA(encoderA), .encoderB(encoderB), .digitPositions(digitPositions),
        .ledGroupEnable(ledGroupEnable), .segmentDrive(segmentDrive),
        .keyGroupDrive_n(keyGroupDrive_n), .keyReturn(keyReturn), .indicators(indicators));

    // Free-running clock
    initial clock = 1'b0;
    always #5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic checkReset();
        check("digitPositions", digitPositions, 32'h0);
        check("ledGroupEnable", ledGroupEnable, 32'h0);
        check("segmentDrive", segmentDrive, 32'h0);
        check("keyGroupDrive_n", keyGroupDrive_n, 32'hFF);
        check("keyReturn", keyReturn, 32'h0);
        check("indicators", indicators, 32'h0);
    endtask

    // One full scan; enc 0 no turn, 1 only high line, 2 both lines
    task automatic runScan(input int enc);
        logic [31:0] oneHot;
        logic [7:0]  pattern;
        logic [7:0]  drive;
        logic [7:0]  ret;
        for (int s = 0; s < panel_scan_pkg::CHAIN_LEN; s++)
        begin
            pattern = 8'h5A ^ s[7:0];
            i_host.step(s == 0, pattern);
            if (s == 0 && enc != 0)
            begin
                encoderB = (enc == 2);
                tick(6);
                encoderA = 1'b1;
                tick(6);
                encoderA = 1'b0;
                tick(6);
            end
            oneHot = 32'h1 << s;
            drive  = ~oneHot[7:0];
            ret    = (s == 1) ? 8'h04 : (s < 8) ? 8'h84 : 8'h00;
            if (s == panel_scan_pkg::FINAL_STAGE)
                ret = (enc == 1) ? 8'h80 : (enc == 2) ? 8'hC0 : 8'h00;
            check("digitPositions", digitPositions, oneHot[13:0]);
            check("ledGroupEnable", ledGroupEnable, oneHot[18:14]);
            check("segmentDrive", segmentDrive, pattern);
            check("keyGroupDrive_n", keyGroupDrive_n, drive);
            check("keyReturn", keyReturn, ret);
        end
        i_host.step(1'b0, 8'h00);
        check("digitPositions", digitPositions, 32'h0);
        check("ledGroupEnable", ledGroupEnable, 32'h0);
    endtask

    task automatic checkIndicators();
        logic [31:0] want;
        want = 32'h0;
        for (int g = 0; g < panel_scan_pkg::ANNUN_GROUPS; g++)
        begin
            i_host.strobe(g, 8'hA1 + g[7:0]);
            want[8*g +: 8] = 8'hA1 + g[7:0];
            check("indicators", indicators, want);
        end
        i_host.strobe(2, 8'h3C);
        want[23:16] = 8'h3C;
        check("indicators", indicators, want);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        rst_n    = 1'b0;
        keySense = 8'h84;
        encoderA = 1'b0;
        encoderB = 1'b0;
        tick(3);
        rst_n = 1'b1;
        tick(6);
        checkReset();
        runScan(1);
        runScan(2);
        runScan(0);
        checkIndicators();
        conclude();
    end

    // Hang limit
    initial
    begin
        #200000;
        fails++;
        conclude();
    end
endmodule // test_led_scan_keyboard_rotary

`default_nettype wire
